// *** inc/isp_pkg.sv ***
package isp_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int IR_LEN    = 8;
  localparam int DR_W      = 32;
  localparam int CELL_W    = 3;
  localparam int BSR_LEN   = CELL_W * PIN_COUNT;
  localparam int ADDR_W    = 4;
  localparam int WORD_W    = 16;
  localparam int WORDS     = 16;
  localparam int ISP_LEN   = 22;
  localparam int SYNC_W    = PIN_COUNT + 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BSR_IN       = 0;
  localparam int BSR_OUT      = 1;
  localparam int BSR_OE       = 2;
  localparam int ISP_ADDR_LSB = 16;
  localparam int ISP_RDSEC    = 20;
  localparam int ISP_WRSEC    = 21;
  localparam int SYNC_TCK     = 0;
  localparam int SYNC_TMS     = 1;
  localparam int SYNC_TDI     = 2;
  localparam int SYNC_PWR     = 3;
  localparam int SYNC_PIN     = 4;

  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0]  ERASED_WORD = 16'hFFFF;
  localparam logic [ISP_LEN-1:0] UNLOCK_KEY  = 22'h2A5C3E;
  localparam logic [IR_LEN-1:0]  IR_CAPTURE  = 8'h01;
  // Identity values are arbitrary
  localparam logic [DR_W-1:0]    ID_CODE     = 32'h0000_1001;
  localparam logic [DR_W-1:0]    USER_CODE   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------
  localparam logic [IR_LEN-1:0] OP_EXTEST   = 8'h00;
  localparam logic [IR_LEN-1:0] OP_SAMPLE   = 8'h01;
  localparam logic [IR_LEN-1:0] OP_INTEST   = 8'h02;
  localparam logic [IR_LEN-1:0] OP_HIGHZ    = 8'hFC;
  localparam logic [IR_LEN-1:0] OP_USERCODE = 8'hFD;
  localparam logic [IR_LEN-1:0] OP_IDCODE   = 8'hFE;
  localparam logic [IR_LEN-1:0] OP_BYPASS   = 8'hFF;
  localparam logic [IR_LEN-1:0] OP_ENTER    = 8'hE8;
  localparam logic [IR_LEN-1:0] OP_PROGRAM  = 8'hEA;
  localparam logic [IR_LEN-1:0] OP_ERASE    = 8'hEC;
  localparam logic [IR_LEN-1:0] OP_VERIFY   = 8'hEE;
  localparam logic [IR_LEN-1:0] OP_EXIT     = 8'hF0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001, TAP_IDLE   = 16'h0002,
    DR_SELECT  = 16'h0004, DR_CAPTURE = 16'h0008,
    DR_SHIFT   = 16'h0010, DR_EXIT1   = 16'h0020,
    DR_PAUSE   = 16'h0040, DR_EXIT2   = 16'h0080,
    DR_UPDATE  = 16'h0100, IR_SELECT  = 16'h0200,
    IR_CAPT    = 16'h0400, IR_SHIFT   = 16'h0800,
    IR_EXIT1   = 16'h1000, IR_PAUSE   = 16'h2000,
    IR_EXIT2   = 16'h4000, IR_UPDATE  = 16'h8000
  } tap_state_type;

  typedef enum logic [4:0] {
    SEL_BYPASS = 5'h01, SEL_ID = 5'h02, SEL_USER = 5'h04,
    SEL_BSR    = 5'h08, SEL_ISP = 5'h10
  } dr_sel_type;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic tap_state_type tap_next(tap_state_type s,
                                             logic tms);
    case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? DR_SELECT : TAP_IDLE;
      DR_SELECT:  tap_next = tms ? IR_SELECT : DR_CAPTURE;
      DR_CAPTURE: tap_next = tms ? DR_EXIT1  : DR_SHIFT;
      DR_SHIFT:   tap_next = tms ? DR_EXIT1  : DR_SHIFT;
      DR_EXIT1:   tap_next = tms ? DR_UPDATE : DR_PAUSE;
      DR_PAUSE:   tap_next = tms ? DR_EXIT2  : DR_PAUSE;
      DR_EXIT2:   tap_next = tms ? DR_UPDATE : DR_SHIFT;
      DR_UPDATE:  tap_next = tms ? DR_SELECT : TAP_IDLE;
      IR_SELECT:  tap_next = tms ? TAP_RESET : IR_CAPT;
      IR_CAPT:    tap_next = tms ? IR_EXIT1  : IR_SHIFT;
      IR_SHIFT:   tap_next = tms ? IR_EXIT1  : IR_SHIFT;
      IR_EXIT1:   tap_next = tms ? IR_UPDATE : IR_PAUSE;
      IR_PAUSE:   tap_next = tms ? IR_EXIT2  : IR_PAUSE;
      IR_EXIT2:   tap_next = tms ? IR_UPDATE : IR_SHIFT;
      IR_UPDATE:  tap_next = tms ? DR_SELECT : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  function automatic dr_sel_type dr_select(logic [IR_LEN-1:0] ir);
    case (ir)
      OP_EXTEST, OP_SAMPLE, OP_INTEST:           dr_select = SEL_BSR;
      OP_IDCODE:                                 dr_select = SEL_ID;
      OP_USERCODE:                               dr_select = SEL_USER;
      OP_PROGRAM, OP_ERASE, OP_VERIFY:           dr_select = SEL_ISP;
      default:                                   dr_select = SEL_BYPASS;
    endcase
  endfunction : dr_select

  function automatic int dr_len(dr_sel_type s);
    case (s)
      SEL_ID, SEL_USER: dr_len = DR_W;
      SEL_BSR:          dr_len = BSR_LEN;
      SEL_ISP:          dr_len = ISP_LEN;
      default:          dr_len = 1;
    endcase
  endfunction : dr_len

endpackage : isp_pkg

// *** verilog/tap_pin_sync.sv ***
`timescale 1ns/1ps
module tap_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Pins in and out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : tap_pin_sync

// *** verilog/isp_security_access_control.sv ***
`timescale 1ns/1ps
module isp_security_access_control import isp_pkg::*; (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Test access port
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe,
  // Supply monitor
  input  wire logic                 pwr_good,
  // User pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe,
  output logic      [PIN_COUNT-1:0] pin_pullup,
  // Core logic side
  input  wire logic [PIN_COUNT-1:0] core_out,
  input  wire logic [PIN_COUNT-1:0] core_oe,
  output logic      [PIN_COUNT-1:0] core_in,
  // Status
  output logic                      prog_mode,
  output logic                      programmed,
  output logic                      sec_read,
  output logic                      sec_write,
  output logic                      op_done,
  output logic                      op_reject
);

  // ---------------------------------------------------------------
  // Pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0]    sync_s;
  logic                 tck_q;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 quiet;
  logic [PIN_COUNT-1:0] pin_s;

  tap_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({pin_in, pwr_good, tdi, tms, tck}),
    .sync_out (sync_s)
  );

  assign pin_s    = sync_s[SYNC_PIN +: PIN_COUNT];
  assign tck_rise = sync_s[SYNC_TCK] & ~tck_q;
  assign tck_fall = ~sync_s[SYNC_TCK] & tck_q;
  assign quiet    = ~sync_s[SYNC_PWR];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= sync_s[SYNC_TCK];
    end
  end

  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  tap_state_type state_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= TAP_RESET;
    end else if (quiet) begin
      state_q <= TAP_RESET;
    end else if (tck_rise) begin
      state_q <= tap_next(state_q, sync_s[SYNC_TMS]);
    end
  end

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  logic [IR_LEN-1:0] ir_shift_q;
  logic [IR_LEN-1:0] ir_q;
  dr_sel_type        sel;

  assign sel = dr_select(ir_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_shift_q <= IR_CAPTURE;
      ir_q       <= OP_IDCODE;
    end else if (state_q == TAP_RESET) begin
      ir_q <= OP_IDCODE;
    end else if (tck_rise && state_q == IR_CAPT) begin
      ir_shift_q <= IR_CAPTURE;
    end else if (tck_rise && state_q == IR_SHIFT) begin
      ir_shift_q <= {sync_s[SYNC_TDI], ir_shift_q[IR_LEN-1:1]};
    end else if (tck_fall && state_q == IR_UPDATE) begin
      ir_q <= ir_shift_q;
    end
  end

  // ---------------------------------------------------------------
  // Programming mode
  // ---------------------------------------------------------------
  logic prog_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_q <= 1'b0;
    end else if (quiet) begin
      prog_q <= 1'b0;
    end else if (tck_fall && state_q == IR_UPDATE) begin
      if (ir_shift_q == OP_ENTER) begin
        prog_q <= 1'b1;
      end else if (ir_shift_q == OP_EXIT) begin
        prog_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------
  logic [DR_W-1:0]      dr_q;
  logic [BSR_LEN-1:0]   bsr_cap;
  logic [BSR_LEN-1:0]   bsr_upd_q;
  logic [WORD_W-1:0]    mem_q [WORDS];
  logic [ADDR_W-1:0]    addr_q;
  logic                 sec_r_q;
  logic                 sec_w_q;
  logic                 prgd_q;
  logic [WORD_W-1:0]    rd_word;
  logic [ADDR_W-1:0]    dr_addr;
  logic [WORD_W-1:0]    dr_data;

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_cell
    assign bsr_cap[CELL_W*i + BSR_IN]  = pin_s[i];
    assign bsr_cap[CELL_W*i + BSR_OUT] = core_out[i];
    assign bsr_cap[CELL_W*i + BSR_OE]  = core_oe[i];
  end

  assign rd_word = (ir_q == OP_VERIFY && !sec_r_q)
                   ? mem_q[addr_q] : '0;
  assign dr_addr = dr_q[ISP_ADDR_LSB +: ADDR_W];
  assign dr_data = dr_q[WORD_W-1:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dr_q <= '0;
    end else if (tck_rise && state_q == DR_CAPTURE) begin
      case (sel)
        SEL_ID:   dr_q <= ID_CODE;
        SEL_USER: dr_q <= USER_CODE;
        SEL_BSR:  dr_q <= DR_W'(bsr_cap);
        SEL_ISP:  dr_q <= DR_W'({sec_w_q, sec_r_q, addr_q, rd_word});
        default:  dr_q <= '0;
      endcase
    end else if (tck_rise && state_q == DR_SHIFT) begin
      dr_q                  <= {1'b0, dr_q[DR_W-1:1]};
      dr_q[dr_len(sel) - 1] <= sync_s[SYNC_TDI];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bsr_upd_q <= '0;
    end else if (tck_fall && state_q == DR_UPDATE && sel == SEL_BSR) begin
      bsr_upd_q <= dr_q[BSR_LEN-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Pattern store and security
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int w = 0; w < WORDS; w++) begin
        mem_q[w] <= ERASED_WORD;
      end
      addr_q    <= '0;
      sec_r_q   <= 1'b0;
      sec_w_q   <= 1'b0;
      prgd_q    <= 1'b0;
      op_done   <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      op_done   <= 1'b0;
      op_reject <= 1'b0;
      if (tck_fall && state_q == DR_UPDATE && sel == SEL_ISP) begin
        if (!prog_q) begin
          op_reject <= 1'b1;
        end else if (ir_q == OP_PROGRAM) begin
          if (sec_r_q || sec_w_q) begin
            op_reject <= 1'b1;
          end else begin
            mem_q[dr_addr] <= dr_data;
            sec_r_q <= dr_q[ISP_RDSEC];
            sec_w_q <= dr_q[ISP_WRSEC];
            prgd_q  <= 1'b1;
            op_done <= 1'b1;
          end
        end else if (ir_q == OP_ERASE) begin
          if (sec_w_q && dr_q[ISP_LEN-1:0] == UNLOCK_KEY) begin
            sec_w_q <= 1'b0;
            op_done <= 1'b1;
          end else if (sec_w_q) begin
            op_reject <= 1'b1;
          end else begin
            for (int w = 0; w < WORDS; w++) begin
              mem_q[w] <= ERASED_WORD;
            end
            sec_r_q <= 1'b0;
            prgd_q  <= 1'b0;
            op_done <= 1'b1;
          end
        end else begin
          addr_q <= dr_addr;
          if (sec_r_q) begin
            op_reject <= 1'b1;
          end else begin
            op_done <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (quiet) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (state_q == IR_SHIFT) || (state_q == DR_SHIFT);
      tdo    <= (state_q == IR_SHIFT) ? ir_shift_q[0] : dr_q[0];
    end
  end

  // ---------------------------------------------------------------
  // User pin control
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_pullup <= '1;
      core_in    <= '0;
    end else begin
      pin_out <= core_out;
      core_in <= (prgd_q && !prog_q && !quiet) ? pin_s : '0;
      if (quiet || prog_q) begin
        pin_oe     <= '0;
        pin_pullup <= '1;
      end else if (ir_q == OP_HIGHZ) begin
        pin_oe     <= '0;
        pin_pullup <= {PIN_COUNT{~prgd_q}};
      end else if (ir_q == OP_EXTEST) begin
        for (int i = 0; i < PIN_COUNT; i++) begin
          pin_out[i] <= bsr_upd_q[CELL_W*i + BSR_OUT];
          pin_oe[i]  <= bsr_upd_q[CELL_W*i + BSR_OE];
        end
        pin_pullup <= {PIN_COUNT{~prgd_q}};
      end else if (!prgd_q) begin
        pin_oe     <= '0;
        pin_pullup <= '1;
      end else begin
        pin_oe     <= core_oe;
        pin_pullup <= '0;
      end
      if (ir_q == OP_INTEST && !quiet && !prog_q) begin
        for (int i = 0; i < PIN_COUNT; i++) begin
          core_in[i] <= bsr_upd_q[CELL_W*i + BSR_IN];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_mode  <= 1'b0;
      programmed <= 1'b0;
      sec_read   <= 1'b0;
      sec_write  <= 1'b0;
    end else begin
      prog_mode  <= prog_q;
      programmed <= prgd_q;
      sec_read   <= sec_r_q;
      sec_write  <= sec_w_q;
    end
  end

endmodule : isp_security_access_control

// *** test/isp_checker.sv ***
`timescale 1ns/1ps
module isp_checker import isp_pkg::*; (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Watched ports
  input wire logic                 pwr_good,
  input wire logic                 tdo_oe,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] pin_pullup,
  input wire logic [PIN_COUNT-1:0] core_in,
  input wire logic                 prog_mode,
  input wire logic                 programmed,
  input wire logic                 sec_read,
  input wire logic                 sec_write,
  input wire logic                 op_done,
  input wire logic                 op_reject
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_prog_float;
    prog_mode ##1 prog_mode |-> pin_oe == '0 && &pin_pullup;
  endproperty
  a_prog_float: assert property (p_prog_float)
    else $error("user pins driven while programming");

  property p_quiet;
    !pwr_good [*5] |-> pin_oe == '0 && &pin_pullup && !prog_mode
                       && !tdo_oe && core_in == '0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("not quiescent while supply low");

  property p_user_pull;
    (pwr_good && programmed && !prog_mode) [*6] |-> pin_pullup == '0;
  endproperty
  a_user_pull: assert property (p_user_pull)
    else $error("pull-ups on in user operation");

  property p_erased_pull;
    !programmed ##1 !programmed |-> &pin_pullup;
  endproperty
  a_erased_pull: assert property (p_erased_pull)
    else $error("pull-ups off while erased");

  property p_rdsec_erase;
    op_done && sec_read && !sec_write |-> ##[1:2] !programmed && !sec_read;
  endproperty
  a_rdsec_erase: assert property (p_rdsec_erase)
    else $error("erase under read lock did not clear");

  property p_fell_read;
    $fell(sec_read) |-> !programmed;
  endproperty
  a_fell_read: assert property (p_fell_read)
    else $error("read lock cleared without erase");

  property p_write_lock;
    sec_write |=> $stable(programmed);
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("pattern state changed under write lock");

  property p_reject_keep;
    op_reject |=> ($stable(sec_read) && $stable(sec_write)
                   && $stable(programmed)) [*2];
  endproperty
  a_reject_keep: assert property (p_reject_keep)
    else $error("refused operation changed state");

  property p_op_mode;
    op_done |-> prog_mode && !op_reject;
  endproperty
  a_op_mode: assert property (p_op_mode)
    else $error("operation done outside programming mode");
endmodule : isp_checker

bind isp_security_access_control isp_checker u_chk (
  .clk, .sys_rst, .pwr_good, .tdo_oe, .pin_oe, .pin_pullup, .core_in,
  .prog_mode, .programmed, .sec_read, .sec_write, .op_done, .op_reject
);

// *** test/isp_host.sv ***
`timescale 1ns/1ps
module isp_host (
  // Clock
  input  wire logic clk,
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // ---------------
  // Host sequencing
  // ---------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock of 25 system clocks
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (11) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (13) @(negedge clk);
    tck = 1'b0;
  endtask : step

  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tap_reset

  // Idle to shift, n bits LSB first, update, back to idle
  task automatic shift(input logic ir, input logic [31:0] v, input int n,
                       output logic [31:0] c);
    logic q;
    c = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], q);
      c[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : shift
endmodule : isp_host

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench import isp_pkg::*; ();
  logic                 clk, sys_rst, pwr_good, tck, tms, tdi, tdo, tdo_oe;
  logic                 prog_mode, programmed, sec_read, sec_write;
  logic                 op_done, op_reject;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [PIN_COUNT-1:0] core_out, core_oe, core_in;
  logic [31:0]          cap;
  int                   n_fail, checks_done, n_done, n_rej;

  isp_security_access_control dut (
    .clk, .sys_rst, .tck, .tms, .tdi, .tdo, .tdo_oe, .pwr_good, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .core_out, .core_oe, .core_in,
    .prog_mode, .programmed, .sec_read, .sec_write, .op_done, .op_reject
  );
  isp_host host (.clk, .tck, .tms, .tdi, .tdo);

  // -------
  // Helpers
  // -------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (op_done === 1'b1)
      n_done++;
    if (op_reject === 1'b1)
      n_rej++;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic st(input logic [3:0] e);
    check("status", {prog_mode, programmed, sec_read, sec_write}, e);
  endtask : st

  task automatic isp(input logic [7:0] op, input logic [21:0] w,
                     input logic ed, input logic er);
    int d0;
    int r0;
    d0 = n_done;
    r0 = n_rej;
    host.shift(1'b1, {24'h0, op}, IR_LEN, cap);
    host.shift(1'b0, {10'h0, w}, ISP_LEN, cap);
    check("op_done", n_done != d0, ed);
    check("op_reject", n_rej != r0, er);
  endtask : isp

  task automatic summarize();
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // ---------
  // Scenarios
  // ---------
  task automatic t_std();
    logic [7:0]  ops [7] = '{OP_IDCODE, OP_USERCODE, OP_BYPASS, OP_HIGHZ,
                             OP_SAMPLE, OP_EXTEST, OP_INTEST};
    logic [31:0] exp [4] = '{ID_CODE, USER_CODE, 32'h0, 32'h0};
    int          len [7] = '{32, 32, 1, 1, 24, 24, 24};
    check("pin_oe", pin_oe, 8'h00);
    check("pullup", pin_pullup, 8'hFF);
    st(4'h0);
    host.tap_reset();
    host.shift(1'b0, 32'h0, DR_W, cap);
    check("idcode", cap, ID_CODE);
    for (int i = 0; i < 7; i++) begin
      host.shift(1'b1, {24'h0, ops[i]}, IR_LEN, cap);
      check("ir capture", cap[7:0], IR_CAPTURE);
      host.shift(1'b0, (i > 4) ? 32'h00FF_FFFF : 32'h0, len[i], cap);
      if (i < 4)
        check("dr capture", cap, exp[i]);
      if (i == 4)
        for (int j = 0; j < PIN_COUNT; j++)
          check("sample", cap[3*j], pin_in[j]);
      if (i == 5) begin
        check("extest out", pin_out, 8'hFF);
        check("extest oe", pin_oe, 8'hFF);
      end
      if (i == 6) begin
        check("intest", core_in, 8'hFF);
        check("pin_oe", pin_oe, 8'h00);
      end
    end
  endtask : t_std

  task automatic t_prog();
    host.shift(1'b1, {24'h0, OP_ENTER}, IR_LEN, cap);
    st(4'h8);
    isp(OP_PROGRAM, {2'b00, 4'h3, 16'h1234}, 1'b1, 1'b0);
    isp(OP_VERIFY, {2'b00, 4'h3, 16'h0}, 1'b1, 1'b0);
    isp(OP_VERIFY, {2'b00, 4'h3, 16'h0}, 1'b1, 1'b0);
    check("verify", cap[21:0], {2'b00, 4'h3, 16'h1234});
    isp(OP_PROGRAM, {2'b01, 4'h5, 16'hBEEF}, 1'b1, 1'b0);
    st(4'hE);
    check("pin_oe", pin_oe, 8'h00);
    check("pullup", pin_pullup, 8'hFF);
    isp(OP_VERIFY, {2'b00, 4'h5, 16'h0}, 1'b0, 1'b1);
    isp(OP_VERIFY, {2'b00, 4'h5, 16'h0}, 1'b0, 1'b1);
    check("verify", cap[15:0], 16'h0000);
    isp(OP_PROGRAM, {2'b00, 4'h3, 16'h0}, 1'b0, 1'b1);
    st(4'hE);
    isp(OP_ERASE, 22'h0, 1'b1, 1'b0);
    st(4'h8);
    isp(OP_VERIFY, {2'b00, 4'h3, 16'h0}, 1'b1, 1'b0);
    isp(OP_VERIFY, {2'b00, 4'h3, 16'h0}, 1'b1, 1'b0);
    check("erased", cap[15:0], ERASED_WORD);
  endtask : t_prog

  task automatic t_write();
    isp(OP_PROGRAM, {2'b10, 4'h1, 16'h00A5}, 1'b1, 1'b0);
    st(4'hD);
    isp(OP_PROGRAM, {2'b00, 4'h1, 16'h0}, 1'b0, 1'b1);
    isp(OP_ERASE, 22'h0, 1'b0, 1'b1);
    st(4'hD);
    isp(OP_ERASE, UNLOCK_KEY, 1'b1, 1'b0);
    st(4'hC);
    isp(OP_PROGRAM, {2'b11, 4'h2, 16'h5A5A}, 1'b1, 1'b0);
    st(4'hF);
    isp(OP_ERASE, 22'h0, 1'b0, 1'b1);
    isp(OP_ERASE, UNLOCK_KEY, 1'b1, 1'b0);
    st(4'hE);
    isp(OP_ERASE, 22'h0, 1'b1, 1'b0);
    isp(OP_PROGRAM, {2'b00, 4'h0, 16'h0C3A}, 1'b1, 1'b0);
    st(4'hC);
  endtask : t_write

  task automatic t_user();
    host.shift(1'b1, {24'h0, OP_EXIT}, IR_LEN, cap);
    host.shift(1'b1, {24'h0, OP_BYPASS}, IR_LEN, cap);
    st(4'h4);
    check("pin_out", pin_out, core_out);
    check("pin_oe", pin_oe, core_oe);
    check("pullup", pin_pullup, 8'h00);
    check("core_in", core_in, pin_in);
    isp(OP_PROGRAM, {2'b00, 4'h0, 16'h0}, 1'b0, 1'b1);
  endtask : t_user

  task automatic t_power();
    @(negedge clk);
    pwr_good = 1'b0;
    repeat (10) @(negedge clk);
    check("pin_oe", pin_oe, 8'h00);
    check("pullup", pin_pullup, 8'hFF);
    check("core_in", core_in, 8'h00);
    st(4'h4);
    pwr_good = 1'b1;
    repeat (10) @(negedge clk);
    host.tap_reset();
    host.shift(1'b0, 32'h0, DR_W, cap);
    check("idcode", cap, ID_CODE);
  endtask : t_power

  initial begin
    sys_rst = 1'b1;
    pwr_good = 1'b1;
    pin_in = 8'hA5;
    core_out = 8'h3C;
    core_oe = 8'h0F;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk);
    t_std();
    t_prog();
    t_write();
    t_user();
    t_power();
    summarize();
  end

  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule : testbench
